/* hw/ivcs_defs.svh */
// offsets, field positions, reset values, vector address and context size of the interrupt block
`ifndef IVCS_DEFS_SVH
`define IVCS_DEFS_SVH
`define IVCS_OFF_CTRL     8'h10
`define IVCS_OFF_EN0      8'h11
`define IVCS_OFF_EN1      8'h12
`define IVCS_OFF_EN4      8'h15
`define IVCS_OFF_FLAG0    8'h16
`define IVCS_OFF_SHADOW   8'h20
`define IVCS_SHADOW_MASK  8'hF8
`define IVCS_CTRL_GIE     7
`define IVCS_CTRL_PERIPHERAL_IRQ_ENABLE    6
`define IVCS_CTRL_EDGE    0
`define IVCS_CTRL_RESET   8'h01
`define IVCS_CTRL_MASK    8'hC1
`define IVCS_EN_RESET     8'h00
`define IVCS_EN0_MASK     8'h31
`define IVCS_EN0_TMR0     5
`define IVCS_EN0_PINCHG   4
`define IVCS_EN0_EXT      0
`define IVCS_STAT_TO      4
`define IVCS_STAT_PD      3
`define IVCS_VECTOR       15'h0004
`define IVCS_CTX_BYTES    8
`endif

/* hw/ivcs_pkg.sv */
// types shared by the interrupt vectoring block
package ivcs_pkg;
    typedef enum logic [1:0] {
        IVCS_RUN    = 2'b00,
        IVCS_FLUSH  = 2'b01,
        IVCS_VECTOR = 2'b10
    } ivcs_state_e;
    typedef logic [63:0] ivcs_ctx_t;
endpackage

/* hw/ivcs_shadow_if.sv */
// signals between the interrupt block and its shadow context store
interface ivcs_shadow_if;
    logic        saveAll;
    logic [63:0] liveCtx;
    logic        swWr;
    logic [2:0]  swIdx;
    logic [7:0]  swData;
    logic [63:0] ctxOut;
    logic [7:0]  rdData;
    modport store (input saveAll, liveCtx, swWr, swIdx, swData, output ctxOut, rdData);
    modport user  (output saveAll, liveCtx, swWr, swIdx, swData, input ctxOut, rdData);
endinterface

/* hw/ivcs_shadow_mem.sv */
// shadow context store: eight bytes, saved whole on entry, byte access for software
`include "ivcs_defs.svh"
module ivcs_shadow_mem
    import ivcs_pkg::*;
(
    input  wire logic       clk,    // instruction clock
    input  wire logic       rstN,   // synchronised reset, active low
    ivcs_shadow_if.store    sh      // save, access and read-back
);
    logic [7:0] memReg [0:`IVCS_CTX_BYTES-1];

    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    // whole save wins over a software byte write in the same cycle
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < `IVCS_CTX_BYTES; i++) begin
                memReg[i] <= 8'h00;
            end
        end else if (sh.saveAll) begin
            for (int i = 0; i < `IVCS_CTX_BYTES; i++) begin
                memReg[i] <= sh.liveCtx[i*8 +: 8];
            end
        end else if (sh.swWr) begin
            memReg[sh.swIdx] <= sh.swData;
        end
    end

    // read data come from a register, one cycle after the index
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            sh.rdData <= 8'h00;
        end else begin
            sh.rdData <= memReg[sh.swIdx];
        end
    end

    // whole image for the restore path
    always_comb begin
        for (int i = 0; i < `IVCS_CTX_BYTES; i++) begin
            sh.ctxOut[i*8 +: 8] = memReg[i];
        end
    end
endmodule

/* hw/ivcs_top.sv */
// interrupt gating, external pin edge, vectoring, wake and context shadowing
//
// Chosen here: the placing of the registers and the strobed register port.
`include "ivcs_defs.svh"

module ivcs_top
    import ivcs_pkg::*;
(
    input  wire logic        core_clk,      // instruction clock, 25 MHz
    input  wire logic        nrst,          // asynchronous reset, active low
    input  wire logic [7:0]  regAddr,       // register address
    input  wire logic [7:0]  regWdata,      // register write data
    input  wire logic        regWr,         // write strobe
    input  wire logic        regRd,         // read strobe
    output logic      [7:0]  regRdata,      // read data, cycle after strobe
    input  wire logic        extPin,        // external interrupt pin
    input  wire logic        tmr0Event,     // timer0 overflow pulse
    input  wire logic        pinChangeAny,  // pin change flags, ored level
    input  wire logic [31:0] periphFlags,   // flags matching enables 1..4
    input  wire logic        cycleEnd,      // pulse at end of each instr cycle
    input  wire logic        sleepMode,     // core is asleep
    input  wire logic        retfieExec,    // return-from-interrupt executes
    input  wire logic [14:0] curPc,         // address to return to
    input  wire ivcs_ctx_t   liveCtx,       // live core context bytes
    output logic             wakeReq,       // wake the core from sleep
    output logic             flushReq,      // drop prefetched instruction
    output logic             stackPush,     // push returnPc
    output logic      [14:0] returnPc,      // pushed return address
    output logic             stackPop,      // pop return address
    output logic             pcLoad,        // load pcLoadAddr into pc
    output logic      [14:0] pcLoadAddr,    // vector address
    output logic             ctxRestore,    // load restoreCtx into core
    output ivcs_ctx_t        restoreCtx     // context to restore
);
    // -------------------------------------------------------------
    // reset release and pin synchroniser
    // -------------------------------------------------------------
    logic rstSync1Reg;
    logic rstN;
    logic extSync1Reg;
    logic extSync2Reg;
    logic extPrevReg;

    // release is delayed two edges, assertion stays immediate
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1Reg <= 1'b0;
            rstN        <= 1'b0;
        end else begin
            rstSync1Reg <= 1'b1;
            rstN        <= rstSync1Reg;
        end
    end

    // first stage feeds only the second
    // reset low suits a pin idling low; one idling high shows a rise after reset
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            extSync1Reg <= 1'b0;
            extSync2Reg <= 1'b0;
            extPrevReg  <= 1'b0;
        end else begin
            extSync1Reg <= extPin;
            extSync2Reg <= extSync1Reg;
            extPrevReg  <= extSync2Reg;
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [7:0] ctrlReg;
    logic [7:0] en0Reg;
    logic [7:0] enPerReg [0:3];
    logic       tmr0FlagReg;
    logic       extFlagReg;
    ivcs_state_e stateReg;
    ivcs_state_e stateNext;
    logic       postWakeReg;
    logic       sleepPrevReg;

    // address decode
    wire hitCtrl   = (regAddr == `IVCS_OFF_CTRL);
    wire hitEn0    = (regAddr == `IVCS_OFF_EN0);
    wire hitEnPer  = (regAddr >= `IVCS_OFF_EN1) && (regAddr <= `IVCS_OFF_EN4);
    wire hitFlag0  = (regAddr == `IVCS_OFF_FLAG0);
    wire hitShadow = ((regAddr & `IVCS_SHADOW_MASK) == `IVCS_OFF_SHADOW);
    wire flagWr    = regWr && hitFlag0;
    wire [1:0] perIdx = 2'(regAddr - `IVCS_OFF_EN1);

    // control fields
    wire global_irq_enable  = ctrlReg[`IVCS_CTRL_GIE];
    wire peripheral_irq_enable = ctrlReg[`IVCS_CTRL_PERIPHERAL_IRQ_ENABLE];
    wire edgeRising = ctrlReg[`IVCS_CTRL_EDGE];

    // edge detection on the synchronised pin
    wire extRise  = extSync2Reg & ~extPrevReg;
    wire extFall  = ~extSync2Reg & extPrevReg;
    wire extEdge  = edgeRising ? extRise : extFall;

    // gating of requests
    wire [31:0] perEnables = {enPerReg[3], enPerReg[2], enPerReg[1], enPerReg[0]};
    wire perAny   = |(periphFlags & perEnables);
    wire core0Any = (extFlagReg & en0Reg[`IVCS_EN0_EXT])
                  | (tmr0FlagReg & en0Reg[`IVCS_EN0_TMR0])
                  | (pinChangeAny & en0Reg[`IVCS_EN0_PINCHG]);
    wire pending  = core0Any | (peripheral_irq_enable & perAny);
    // no entry while asleep, nor before the instruction after sleep has run;
    // the exit edge itself is covered too, as postWakeReg only rises after it
    wire wakeExit = sleepPrevReg & ~sleepMode;
    wire entryBlock = sleepMode | wakeExit | postWakeReg | retfieExec;
    wire takeIrq  = (stateReg == IVCS_RUN) && cycleEnd && global_irq_enable && pending
                    && !entryBlock;

    // wake needs only the source enable, not the global one
    // limitation: the pin is sampled on core_clk, so that clock must keep running
    assign wakeReq = sleepMode & (core0Any | perAny);

    // control and enable registers; reset clears every enable
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ctrlReg <= `IVCS_CTRL_RESET;
            en0Reg  <= `IVCS_EN_RESET;
        end else begin
            if (regWr && hitCtrl) begin
                ctrlReg <= regWdata & `IVCS_CTRL_MASK;
            end
            if (takeIrq) begin
                ctrlReg[`IVCS_CTRL_GIE] <= 1'b0;
            end else if (retfieExec) begin
                ctrlReg[`IVCS_CTRL_GIE] <= 1'b1;
            end
            if (regWr && hitEn0) begin
                en0Reg <= regWdata & `IVCS_EN0_MASK;
            end
        end
    end

    // peripheral enable registers one to four
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < 4; i++) begin
                enPerReg[i] <= `IVCS_EN_RESET;
            end
        end else if (regWr && hitEnPer) begin
            enPerReg[perIdx] <= regWdata;
        end
    end

    // flags: a set in the clearing cycle wins, enables play no part
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            extFlagReg  <= 1'b0;
            tmr0FlagReg <= 1'b0;
        end else begin
            if (extEdge) begin
                extFlagReg <= 1'b1;
            end else if (flagWr && !regWdata[`IVCS_EN0_EXT]) begin
                extFlagReg <= 1'b0;
            end
            if (tmr0Event) begin
                tmr0FlagReg <= 1'b1;
            end else if (flagWr && !regWdata[`IVCS_EN0_TMR0]) begin
                tmr0FlagReg <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // wake bookkeeping
    // -------------------------------------------------------------
    // after sleep one instruction must finish before any entry
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            sleepPrevReg <= 1'b0;
            postWakeReg  <= 1'b0;
        end else begin
            sleepPrevReg <= sleepMode;
            if (wakeExit) begin
                postWakeReg <= 1'b1;
            end else if (cycleEnd) begin
                postWakeReg <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // entry sequencer
    // -------------------------------------------------------------
    // event cycle, flush cycle, push cycle, then the vector executes
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            IVCS_RUN: begin
                if (takeIrq) begin
                    stateNext = IVCS_FLUSH;
                end
            end
            IVCS_FLUSH: begin
                if (cycleEnd) begin
                    stateNext = IVCS_VECTOR;
                end
            end
            IVCS_VECTOR: begin
                if (cycleEnd) begin
                    stateNext = IVCS_RUN;
                end
            end
            default: begin
                stateNext = IVCS_RUN;
            end
        endcase
    end

    // entry strobes, one per instruction boundary
    wire enterPush = (stateReg == IVCS_FLUSH) && cycleEnd;
    wire enterLoad = (stateReg == IVCS_VECTOR) && cycleEnd;

    // status is saved without timeout and power-down bits
    logic [63:0] saveCtx;
    always_comb begin
        saveCtx = liveCtx;
        saveCtx[8 + `IVCS_STAT_TO] = 1'b0;
        saveCtx[8 + `IVCS_STAT_PD] = 1'b0;
    end

    // shadow store
    ivcs_shadow_if shIf ();
    assign shIf.saveAll = takeIrq;
    assign shIf.liveCtx = saveCtx;
    assign shIf.swWr    = regWr && hitShadow;
    assign shIf.swIdx   = regAddr[2:0];
    assign shIf.swData  = regWdata;

    ivcs_shadow_mem uShadow (
        .clk  (core_clk),
        .rstN (rstN),
        .sh   (shIf)
    );

    // sequencer state and registered core commands
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            stateReg   <= IVCS_RUN;
            flushReq   <= 1'b0;
            stackPush  <= 1'b0;
            returnPc   <= 15'h0000;
            stackPop   <= 1'b0;
            pcLoad     <= 1'b0;
            pcLoadAddr <= 15'h0000;
        end else begin
            stateReg   <= stateNext;
            flushReq   <= takeIrq;
            stackPush  <= enterPush;
            stackPop   <= retfieExec;
            pcLoad     <= enterLoad;
            if (takeIrq) begin
                returnPc <= curPc;
            end
            if (enterLoad) begin
                pcLoadAddr <= `IVCS_VECTOR;
            end
        end
    end

    // restore keeps live timeout and power-down, everything else from shadow
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ctxRestore <= 1'b0;
            restoreCtx <= 64'h0000_0000_0000_0000;
        end else begin
            ctxRestore <= retfieExec;
            if (retfieExec) begin
                restoreCtx <= shIf.ctxOut;
                restoreCtx[8 + `IVCS_STAT_TO] <= liveCtx[8 + `IVCS_STAT_TO];
                restoreCtx[8 + `IVCS_STAT_PD] <= liveCtx[8 + `IVCS_STAT_PD];
            end
        end
    end

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    // reads have no side effects, so a flag never clears by being read
    logic       rdPendReg;
    logic       rdShadowReg;
    logic [7:0] rdHoldReg;
    logic [7:0] rdMux;

    // unmapped addresses read zero
    always_comb begin
        if (hitCtrl) begin
            rdMux = ctrlReg;
        end else if (hitEn0) begin
            rdMux = en0Reg;
        end else if (hitEnPer) begin
            rdMux = enPerReg[perIdx];
        end else if (hitFlag0) begin
            rdMux = {2'b00, tmr0FlagReg, pinChangeAny, 3'b000, extFlagReg};
        end else begin
            rdMux = 8'h00;
        end
    end

    // shadow bytes come straight from the store's read register
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            rdPendReg   <= 1'b0;
            rdShadowReg <= 1'b0;
            rdHoldReg   <= 8'h00;
        end else begin
            rdPendReg   <= regRd;
            rdShadowReg <= regRd && hitShadow;
            rdHoldReg   <= regRd ? rdMux : 8'h00;
        end
    end

    // data stand only in the cycle after the strobe
    assign regRdata = !rdPendReg ? 8'h00 : (rdShadowReg ? shIf.rdData : rdHoldReg);
endmodule

/* tb/ivcs_top_sva.sv */
// concurrent checks on the ports of the interrupt vectoring block
`include "ivcs_defs.svh"
module ivcs_top_sva
    import ivcs_pkg::*;
(
    input wire logic        core_clk,    // instruction clock
    input wire logic        nrst,        // reset, active low
    input wire logic [7:0]  regAddr,     // register address
    input wire logic        regRd,       // read strobe
    input wire logic [7:0]  regRdata,    // read data
    input wire logic        sleepMode,   // core asleep
    input wire logic        retfieExec,  // return executes
    input wire ivcs_ctx_t   liveCtx,     // live context
    input wire logic        wakeReq,     // wake request
    input wire logic        flushReq,    // prefetch flush
    input wire logic        stackPush,   // push pulse
    input wire logic [14:0] returnPc,    // pushed address
    input wire logic        stackPop,    // pop pulse
    input wire logic        pcLoad,      // vector load pulse
    input wire logic [14:0] pcLoadAddr,  // vector address
    input wire logic        ctxRestore,  // restore pulse
    input wire ivcs_ctx_t   restoreCtx   // restored context
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // one clock domain, checks idle in reset
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // entry sequence: flush, push, then vector load, each one boundary apart
    property p_flush_push; flushReq |-> ##[1:4] stackPush; endproperty
    a_flush_push: assert property (p_flush_push) else $error("push missing after flush");
    property p_push_load; stackPush |-> ##[1:4] pcLoad; endproperty
    a_push_load: assert property (p_push_load) else $error("vector load late");
    property p_vec; pcLoad |-> pcLoadAddr == `IVCS_VECTOR; endproperty
    a_vec: assert property (p_vec) else $error("wrong vector address");
    property p_push_pc; stackPush |-> $stable(returnPc); endproperty
    a_push_pc: assert property (p_push_pc) else $error("return address moved");
    property p_no_nest; flushReq |=> !flushReq [*8]; endproperty
    a_no_nest: assert property (p_no_nest) else $error("entry restarted early");
    // return: pop and restore together, status flags kept from live core
    property p_ret; retfieExec |=> stackPop && ctxRestore; endproperty
    a_ret: assert property (p_ret) else $error("return pulses missing");
    property p_ret_status;
        retfieExec |=> restoreCtx[12:11] == $past(liveCtx[12:11]);
    endproperty
    a_ret_status: assert property (p_ret_status) else $error("status flags restored");
    // wake only while asleep; unimplemented control and enable bits read zero
    property p_wake; wakeReq |-> sleepMode; endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_ctrl_bits;
        regRd && regAddr == `IVCS_OFF_CTRL |=> (regRdata & ~`IVCS_CTRL_MASK) == 8'h00;
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits) else $error("control spare bit set");
    property p_en0_bits;
        regRd && regAddr == `IVCS_OFF_EN0 |=> (regRdata & ~`IVCS_EN0_MASK) == 8'h00;
    endproperty
    a_en0_bits: assert property (p_en0_bits) else $error("enable0 spare bit set");
endmodule

bind ivcs_top ivcs_top_sva u_sva (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regRd(regRd),
    .regRdata(regRdata), .sleepMode(sleepMode), .retfieExec(retfieExec),
    .liveCtx(liveCtx), .wakeReq(wakeReq), .flushReq(flushReq), .stackPush(stackPush),
    .returnPc(returnPc), .stackPop(stackPop), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr),
    .ctxRestore(ctxRestore), .restoreCtx(restoreCtx)
);

/* tb/ivcs_core_model.sv */
// core-side partner: instruction cycle pacing, program counter and return stack
module ivcs_core_model (
    input  wire logic        core_clk,   // instruction clock
    input  wire logic        nrst,       // reset, active low
    input  wire logic        stackPush,  // push pulse from block
    input  wire logic [14:0] returnPc,   // address to push
    input  wire logic        stackPop,   // pop pulse from block
    output logic             cycleEnd,   // last clock of each instruction cycle
    output logic      [14:0] curPc,      // address of next instruction
    output logic      [14:0] popPc       // address last popped
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  phase;
    logic [14:0] stack [$];

    // four clocks to an instruction cycle, so latency counts stay in whole cycles
    assign cycleEnd = (phase == 2'h3);

    // pc steps once per cycle; stack keeps every pushed address in order
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase <= 2'h0;
            curPc <= 15'h0100;
            popPc <= 15'h0000;
        end else begin
            phase <= phase + 2'h1;
            if (cycleEnd) curPc <= curPc + 15'h0001;
            if (stackPush) stack.push_back(returnPc);
            if (stackPop && stack.size() > 0) popPc <= stack.pop_back();
        end
    end
endmodule

/* tb/tb_irq_vectoring_and_context_save.sv */
// self-checking bench for the interrupt vectoring block
module tb_irq_vectoring_and_context_save
    import ivcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, nrst, regWr, regRd, extPin, tmr0Event, sleepMode, retfieExec, pinChg;
    logic [7:0]  regAddr, regWdata, regRdata;
    logic [31:0] periphFlags;
    ivcs_ctx_t   liveCtx, restoreCtx;
    logic [14:0] curPc, returnPc, pcLoadAddr, popPc, takePc;
    logic        cycleEnd, wakeReq, flushReq, stackPush, stackPop, pcLoad, ctxRestore;
    int          failures, compares, cycles, n;

    ivcs_top u_dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .extPin(extPin), .tmr0Event(tmr0Event), .pinChangeAny(pinChg),
        .periphFlags(periphFlags), .cycleEnd(cycleEnd), .sleepMode(sleepMode),
        .retfieExec(retfieExec), .curPc(curPc), .liveCtx(liveCtx), .wakeReq(wakeReq),
        .flushReq(flushReq), .stackPush(stackPush), .returnPc(returnPc),
        .stackPop(stackPop), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr),
        .ctxRestore(ctxRestore), .restoreCtx(restoreCtx));
    ivcs_core_model u_core (.core_clk(core_clk), .nrst(nrst), .stackPush(stackPush),
        .returnPc(returnPc), .stackPop(stackPop), .cycleEnd(cycleEnd), .curPc(curPc),
        .popPc(popPc));

    // ----------------------------------------
    // clock, hang guard, take-time pc capture
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // flush comes the cycle after the take edge, when pc has already stepped once
    always @(posedge core_clk) begin
        cycles++;
        if (flushReq === 1'b1) takePc <= curPc - 15'h0001;
        if (cycles == 4000) begin
            failures++;
            $display("[FAIL] %0t run did not finish", $time);
            results;
        end
    end

    // ----------------------------------------
    // bus cycles and comparison helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic clks(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 chk({56'h0, regRdata}, {56'h0, exp});
    endtask
    task automatic pin(input logic v, input int k);
        @(posedge core_clk);
        extPin <= v;
        clks(k);
    endtask
    // counts clocks until the vector load pulse, bounded by lim
    task automatic wait_take(input int lim);
        n = 0;
        while (pcLoad !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk({63'h0, pcLoad}, 64'h1);
        chk({49'h0, pcLoadAddr}, 64'h4);
    endtask
    task automatic no_take(input int lim);
        logic seen;
        seen = 1'b0;
        repeat (lim) begin
            @(posedge core_clk);
            #1 seen = seen | flushReq;
        end
        chk({63'h0, seen}, 64'h0);
    endtask
    task automatic ret;
        @(posedge core_clk);
        retfieExec <= 1'b1;
        @(posedge core_clk);
        retfieExec <= 1'b0;
        #1 chk({62'h0, stackPop, ctxRestore}, 64'h3);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [7:0] a;
        rc(8'h10, 8'h01);
        for (a = 8'h11; a != 8'h28; a++) rc(a, 8'h00);
        wr(8'h10, 8'h7F);
        rc(8'h10, 8'h41);
        wr(8'h11, 8'hFF);
        rc(8'h11, 8'h31);
        wr(8'h13, 8'hA5);
        rc(8'h13, 8'hA5);
        wr(8'h30, 8'hAA);
        rc(8'h30, 8'h00);
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h00);
        wr(8'h13, 8'h00);
        $display("t_regs done");
    endtask
    // both edge senses: the unselected edge leaves the flag clear
    task automatic t_edge;
        for (int e = 0; e < 2; e++) begin
            pin(e[0], 1);
            wr(8'h10, {7'h00, e[0]});
            clks(4);
            wr(8'h16, 8'h00);
            pin(~e[0], 6);
            rc(8'h16, 8'h00);
            pin(e[0], 6);
            rc(8'h16, 8'h01);
            wr(8'h16, 8'h00);
        end
        $display("t_edge done");
    endtask
    task automatic t_entry;
        @(posedge core_clk);
        liveCtx <= 64'h8877_6655_4433_FF11;
        pin(1'b0, 6);
        wr(8'h11, 8'h01);
        wr(8'h10, 8'h81);
        pin(1'b1, 0);
        wait_take(30);
        chk({63'h0, n <= 20}, 64'h1);
        chk({49'h0, returnPc}, {49'h0, takePc});
        rc(8'h10, 8'h01);
        rc(8'h21, 8'hE7);
        rc(8'h27, 8'h88);
        wr(8'h20, 8'h5A);
        wr(8'h16, 8'h00);
        @(posedge core_clk);
        liveCtx <= 64'h0000_0000_0000_1800;
        ret();
        chk(restoreCtx, 64'h8877_6655_4433_FF5A);
        clks(1);
        #1 chk({49'h0, popPc}, {49'h0, returnPc});
        rc(8'h10, 8'h81);
        $display("t_entry done");
    endtask
    // peripheral source needs both enables; enable0 source needs only global
    task automatic t_gate;
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h01);
        @(posedge core_clk);
        periphFlags <= 32'h0000_0001;
        no_take(24);
        wr(8'h10, 8'hC1);
        wait_take(30);
        @(posedge core_clk);
        periphFlags <= 32'h0000_0000;
        ret();
        wr(8'h10, 8'h81);
        wr(8'h12, 8'h00);
        wr(8'h11, 8'h20);
        @(posedge core_clk);
        tmr0Event <= 1'b1;
        @(posedge core_clk);
        tmr0Event <= 1'b0;
        wait_take(30);
        chk({63'h0, n <= 15}, 64'h1);
        rc(8'h16, 8'h20);
        wr(8'h16, 8'h00);
        ret();
        @(posedge core_clk);
        pinChg <= 1'b1;
        rc(8'h16, 8'h10);
        wr(8'h11, 8'h10);
        wait_take(30);
        @(posedge core_clk);
        pinChg <= 1'b0;
        ret();
        wr(8'h10, 8'h01);
        $display("t_gate done");
    endtask
    task automatic t_sleep;
        wr(8'h11, 8'h01);
        @(posedge core_clk);
        sleepMode <= 1'b1;
        pin(1'b0, 6);
        chk({63'h0, wakeReq}, 64'h0);
        pin(1'b1, 6);
        chk({63'h0, wakeReq}, 64'h1);
        no_take(24);
        wr(8'h11, 8'h00);
        #1 chk({63'h0, wakeReq}, 64'h0);
        wr(8'h11, 8'h01);
        wr(8'h10, 8'h81);
        no_take(12);
        @(posedge core_clk);
        sleepMode <= 1'b0;
        wait_take(30);
        chk({63'h0, n >= 13 && n <= 20}, 64'h1);
        wr(8'h16, 8'h00);
        ret();
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h00);
        $display("t_sleep done");
    endtask

    task automatic results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // reset for three cycles, then wait out the two-flop release
    initial begin
        {nrst, regWr, regRd, extPin, tmr0Event, sleepMode, retfieExec, pinChg} = 8'h00;
        {regAddr, regWdata, periphFlags, liveCtx} = '0;
        clks(3);
        nrst <= 1'b1;
        clks(3);
        t_regs;
        t_edge;
        t_entry;
        t_gate;
        t_sleep;
        results;
    end
endmodule
